// ===== rtl/stpi_interp.sv
module stpi_interp
  import stpi_pkg::*;
#(
  parameter int unsigned DELAY_CYC = DELAY_UNIT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_in_1,
  input wire logic ext_in_2,
  input wire logic ext_in_3,
  output logic ext_out_1,
  output logic ext_out_2,
  output stpi_motion_type motion
);
  logic [7:0] ram [PROG_DEPTH];
  logic [7:0] eeprom [PROG_DEPTH];
  stpi_state_type state_r;
  stpi_cmd_type cur_r, cmd_in, f_cmd;
  stpi_motion_type motion_r;
  logic [6:0] pc_r, next_pc_r, wr_ptr_r, copy_r, loop_pc_r, until_pc_r;
  logic [7:0] loop_cnt_r, tenths_r, reply_r;
  logic [1:0] until_idx_r, wait_idx_r, ext_out_r;
  logic loop_act_r, loop_open_r, until_on_r, prog_mode_r, prog_err_r;
  logic save_pend_r, direct_r, stop_req_r, reply_v_r;
  logic [19:0] ss_r, slew_r, cur_rate_r, inc_r, remain_r, up_r;
  logic [15:0] ramp_r;
  logic [27:0] acc_r, acc_sum;
  logic signed [31:0] pos_r;
  logic [23:0] tick_r;
  logic [19:0] div_n_r, div_q_r;
  logic [16:0] div_rem_r, rem_t;
  logic [4:0] div_i_r;
  logic [31:0] prdata_r;
  logic cmd_wr, rply_rd, running, allowed, app_we, arg_ok, logic_ok, room;
  logic wait_bit, until_bit;
  logic [2:0] app_len, f_len;
  logic [7:0] f_hi;
  logic [31:0] app_bytes;
  logic [2:0] in_vec;
  logic signed [32:0] g_diff;
  logic [19:0] mv_len;
  logic mv_dir;
  logic [7:0] loop_rem;

  // rates are kept in steps per second
  function automatic logic [19:0] times10(input logic [15:0] a);
    times10 = {1'b0, a, 3'b000} + {3'b000, a, 1'b0};
  endfunction

  // out-of-range program reads return zero, seen as an illegal opcode
  function automatic logic [7:0] rd(input logic [6:0] a);
    rd = ({1'b0, a} < DEPTH_B) ? ram[a] : 8'h00;
  endfunction

  // host side decode
  assign cmd_wr = psel && penable && pwrite && (paddr == OFS_CMD);
  assign rply_rd = psel && penable && !pwrite && (paddr == OFS_REPLY);
  assign cmd_in = stpi_cmd_type'(pwdata[27:0]);
  assign running = (state_r != ST_IDLE);
  assign allowed = (cmd_in.op == CH_STAT) || (cmd_in.op == CH_ZERO) || (cmd_in.op == CH_KILL);
  assign in_vec = {ext_in_3, ext_in_2, ext_in_1};
  assign wait_bit = in_vec[wait_idx_r - 2'd1];
  assign until_bit = in_vec[until_idx_r - 2'd1];
  assign acc_sum = acc_r + {8'h00, cur_rate_r};
  assign rem_t = {div_rem_r[15:0], div_n_r[19]};
  assign loop_rem = loop_act_r ? loop_cnt_r : cur_r.arg[7:0] - 8'd1;

  // program entry checks: argument range, loop nesting, storage room
  always_comb begin
    app_len = cmd_len(cmd_in.op);
    case (cmd_in.op)
      CH_PLUS, CH_MINUS: arg_ok = (cmd_in.arg != 20'h0_0000) && (cmd_in.arg <= MOVE_MAX);
      CH_GOTO: arg_ok = (cmd_in.arg <= MOVE_MAX);
      CH_SET, CH_CLR: arg_ok = (cmd_in.arg == 20'h0_0001) || (cmd_in.arg == 20'h0_0002);
      CH_WAIT, CH_UNTIL: arg_ok = (cmd_in.arg != 20'h0_0000) && (cmd_in.arg <= 20'h0_0003);
      CH_SS, CH_SLEW, CH_RAMP: arg_ok = (cmd_in.arg[19:16] == 4'h0);
      CH_LOOP, CH_DELAY: arg_ok = (cmd_in.arg[19:8] == 12'h000);
      default: arg_ok = 1'b1;
    endcase
    logic_ok = !(cmd_in.op == CH_LOOP && cmd_in.arg != 20'h0_0000 && !loop_open_r);
    room = ({1'b0, wr_ptr_r} + {5'h00, app_len}) <= DEPTH_B;
    app_we = cmd_wr && !running && prog_mode_r && (app_len != 3'd0)
      && arg_ok && logic_ok && room && !(cmd_in.op == CH_RUN && prog_err_r);
    case (app_len)
      3'd4: app_bytes = {cmd_in.op, 4'h0, cmd_in.arg};
      3'd3: app_bytes = {cmd_in.op, cmd_in.arg[15:0], 8'h00};
      3'd2: app_bytes = {cmd_in.op, cmd_in.arg[7:0], 16'h0000};
      default: app_bytes = {cmd_in.op, 24'h00_0000};
    endcase
  end

  // fetch decode; an unknown opcode in ram ends the program
  always_comb begin
    f_hi = rd(pc_r + 7'd1);
    f_cmd.op = rd(pc_r);
    f_len = cmd_len(f_cmd.op);
    case (f_len)
      3'd4: f_cmd.arg = {f_hi[3:0], rd(pc_r + 7'd2), rd(pc_r + 7'd3)};
      3'd3: f_cmd.arg = {4'h0, f_hi, rd(pc_r + 7'd2)};
      3'd2: f_cmd.arg = {12'h000, f_hi};
      default: f_cmd.arg = 20'h0_0000;
    endcase
    if (f_len == 3'd0) begin
      f_cmd.op = CH_RUN;
      f_len = 3'd1;
    end
  end

  // move length and direction for relative and absolute moves
  always_comb begin
    g_diff = 33'($signed({13'h0000, cur_r.arg})) - 33'(pos_r);
    if (cur_r.op == CH_GOTO) begin
      mv_dir = g_diff[32];
      mv_len = mv_dir ? 20'(-g_diff) : g_diff[19:0];
    end else begin
      mv_dir = (cur_r.op == CH_MINUS);
      mv_len = cur_r.arg;
    end
  end

  // sequencer, motion profile and host command handling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cur_r <= '0;
      motion_r <= '0;
      pc_r <= 7'h00;
      next_pc_r <= 7'h00;
      wr_ptr_r <= 7'h00;
      copy_r <= 7'h00;
      loop_pc_r <= 7'h00;
      until_pc_r <= 7'h00;
      loop_cnt_r <= 8'h00;
      tenths_r <= 8'h00;
      reply_r <= 8'h00;
      until_idx_r <= 2'd1;
      wait_idx_r <= 2'd1;
      ext_out_r <= 2'b00;
      loop_act_r <= 1'b0;
      loop_open_r <= 1'b0;
      until_on_r <= 1'b0;
      prog_mode_r <= 1'b0;
      prog_err_r <= 1'b0;
      save_pend_r <= 1'b0;
      direct_r <= 1'b0;
      stop_req_r <= 1'b0;
      reply_v_r <= 1'b0;
      ss_r <= SS_RST;
      slew_r <= SLEW_RST;
      ramp_r <= RAMP_RST;
      cur_rate_r <= 20'h0_0000;
      inc_r <= 20'h0_0000;
      remain_r <= 20'h0_0000;
      up_r <= 20'h0_0000;
      acc_r <= 28'h000_0000;
      pos_r <= '0;
      tick_r <= 24'h00_0000;
      div_n_r <= 20'h0_0000;
      div_q_r <= 20'h0_0000;
      div_rem_r <= 17'h0_0000;
      div_i_r <= 5'd0;
    end else begin
      motion_r.step <= 1'b0;
      if (rply_rd) begin
        reply_v_r <= 1'b0; // a reply set in the same cycle still wins below
      end
      unique case (state_r)
        ST_IDLE: begin
        end
        ST_FETCH: begin
          cur_r <= f_cmd;
          next_pc_r <= pc_r + 7'(f_len);
          state_r <= ST_EXEC;
        end
        ST_EXEC: begin
          pc_r <= next_pc_r;
          state_r <= direct_r ? ST_IDLE : ST_FETCH;
          case (cur_r.op)
            CH_PLUS, CH_MINUS, CH_GOTO: begin
              if (mv_len != 20'h0_0000) begin
                remain_r <= mv_len;
                motion_r.dir <= mv_dir;
                motion_r.moving <= 1'b1;
                div_n_r <= (slew_r > ss_r) ? slew_r - ss_r : 20'h0_0000;
                div_q_r <= 20'h0_0000;
                div_rem_r <= 17'h0_0000;
                div_i_r <= 5'd20;
                cur_rate_r <= ss_r;
                up_r <= 20'h0_0000;
                acc_r <= 28'h000_0000;
                state_r <= ST_DIV;
              end
            end
            CH_SS: ss_r <= times10(cur_r.arg[15:0]);
            CH_SLEW: slew_r <= times10(cur_r.arg[15:0]);
            CH_RAMP: ramp_r <= cur_r.arg[15:0];
            CH_SET, CH_CLR: begin
              if (cur_r.arg == 20'h0_0001) ext_out_r[0] <= (cur_r.op == CH_SET);
              if (cur_r.arg == 20'h0_0002) ext_out_r[1] <= (cur_r.op == CH_SET);
            end
            CH_WAIT: begin
              wait_idx_r <= cur_r.arg[1:0];
              state_r <= ST_WAIT;
            end
            CH_UNTIL: begin
              until_on_r <= 1'b1;
              until_idx_r <= cur_r.arg[1:0];
              until_pc_r <= next_pc_r;
            end
            CH_LOOP: begin
              if (cur_r.arg == 20'h0_0000) begin
                loop_pc_r <= next_pc_r;
                loop_act_r <= 1'b0;
              end else if (loop_rem != 8'h00) begin
                pc_r <= loop_pc_r;
                loop_cnt_r <= loop_rem - 8'd1;
                loop_act_r <= 1'b1;
              end else begin
                loop_act_r <= 1'b0;
              end
            end
            CH_DELAY: begin
              if (cur_r.arg[7:0] != 8'h00) begin
                tenths_r <= cur_r.arg[7:0];
                tick_r <= 24'h00_0000;
                state_r <= ST_DELAY;
              end
            end
            CH_RUN: begin
              if (until_on_r && !until_bit) begin
                pc_r <= until_pc_r;
              end else begin
                until_on_r <= 1'b0;
                state_r <= ST_IDLE;
              end
            end
            default: begin
            end
          endcase
        end
        ST_DIV: begin
          // ramp increment per step = (slew - start) / ramp, one bit a cycle
          if (ramp_r == 16'h0000) begin
            inc_r <= 20'h0_0000;
            cur_rate_r <= (slew_r > ss_r) ? slew_r : ss_r;
            state_r <= ST_MOVE;
          end else if (div_i_r == 5'd0) begin
            inc_r <= div_q_r;
            state_r <= ST_MOVE;
          end else begin
            div_n_r <= {div_n_r[18:0], 1'b0};
            div_i_r <= div_i_r - 5'd1;
            if (rem_t >= {1'b0, ramp_r}) begin
              div_rem_r <= rem_t - {1'b0, ramp_r};
              div_q_r <= {div_q_r[18:0], 1'b1};
            end else begin
              div_rem_r <= rem_t;
              div_q_r <= {div_q_r[18:0], 1'b0};
            end
          end
        end
        ST_MOVE: begin
          // phase accumulator: one step each time the sum passes the clock rate
          if (acc_sum >= CLK_HZ_W) begin
            acc_r <= acc_sum - CLK_HZ_W;
            motion_r.step <= 1'b1;
            pos_r <= motion_r.dir ? pos_r - 32'sd1 : pos_r + 32'sd1;
            remain_r <= remain_r - 20'd1;
            if (remain_r == 20'd1) begin
              motion_r.moving <= 1'b0;
              motion_r.ramping <= 1'b0;
              stop_req_r <= 1'b0;
              state_r <= (direct_r || stop_req_r) ? ST_IDLE : ST_FETCH;
            end else if (remain_r - 20'd1 <= up_r) begin
              // symmetric ramp down gives a partial profile on short moves
              cur_rate_r <= (cur_rate_r < ss_r + inc_r) ? ss_r : cur_rate_r - inc_r;
              up_r <= (up_r == 20'h0_0000) ? up_r : up_r - 20'd1;
              motion_r.ramping <= 1'b1;
            end else if (cur_rate_r < slew_r && inc_r != 20'h0_0000) begin
              cur_rate_r <= (cur_rate_r + inc_r > slew_r) ? slew_r : cur_rate_r + inc_r;
              up_r <= up_r + 20'd1;
              motion_r.ramping <= 1'b1;
            end else begin
              motion_r.ramping <= 1'b0;
            end
          end else begin
            acc_r <= acc_sum;
          end
        end
        ST_WAIT: begin
          if (wait_bit) state_r <= direct_r ? ST_IDLE : ST_FETCH;
        end
        ST_DELAY: begin
          if (tick_r == 24'(DELAY_CYC - 1)) begin
            tick_r <= 24'h00_0000;
            tenths_r <= tenths_r - 8'd1;
            if (tenths_r == 8'd1) state_r <= direct_r ? ST_IDLE : ST_FETCH;
          end else begin
            tick_r <= tick_r + 24'd1;
          end
        end
        ST_SAVE: begin
          copy_r <= copy_r + 7'd1;
          if (copy_r == PROG_LAST) begin
            pc_r <= 7'h00;
            direct_r <= 1'b0;
            loop_act_r <= 1'b0;
            until_on_r <= 1'b0;
            state_r <= ST_FETCH;
          end
        end
        ST_LOAD: begin
          copy_r <= copy_r + 7'd1;
          if (copy_r == PROG_LAST) state_r <= ST_IDLE;
        end
      endcase
      // host commands come last so kill and stop override the sequencer
      if (cmd_wr) begin
        if (running && !allowed) begin
          reply_r <= RP_BUSY;
          reply_v_r <= 1'b1;
        end else if (cmd_in.op == CH_STAT) begin
          reply_r <= running ? RP_RUN : RP_READY;
          reply_v_r <= 1'b1;
        end else if (cmd_in.op == CH_KILL) begin
          state_r <= ST_IDLE;
          motion_r.moving <= 1'b0;
          motion_r.ramping <= 1'b0;
          stop_req_r <= 1'b0;
        end else if (cmd_in.op == CH_ZERO) begin
          if (state_r == ST_MOVE || state_r == ST_DIV) begin
            stop_req_r <= 1'b1;
            if (remain_r > up_r + 20'd1) remain_r <= up_r + 20'd1;
          end else if (running) begin
            state_r <= ST_IDLE;
          end
        end else if (prog_mode_r) begin
          if (app_we) begin
            wr_ptr_r <= wr_ptr_r + 7'(app_len);
            if (cmd_in.op == CH_LOOP) loop_open_r <= (cmd_in.arg == 20'h0_0000);
          end else if (cmd_in.op != CH_SAVE) begin
            prog_err_r <= 1'b1;
            reply_r <= RP_ERR;
            reply_v_r <= 1'b1;
          end
          if (cmd_in.op == CH_SAVE) save_pend_r <= 1'b1;
          if (cmd_in.op == CH_RUN) begin
            prog_mode_r <= 1'b0;
            if (app_we && save_pend_r) begin
              copy_r <= 7'h00;
              state_r <= ST_SAVE;
            end else if (app_we) begin
              pc_r <= 7'h00;
              direct_r <= 1'b0;
              loop_act_r <= 1'b0;
              until_on_r <= 1'b0;
              state_r <= ST_FETCH;
            end
          end
        end else if (cmd_in.op == CH_PROG) begin
          prog_mode_r <= 1'b1;
          wr_ptr_r <= 7'h00;
          prog_err_r <= 1'b0;
          save_pend_r <= 1'b0;
          loop_open_r <= 1'b0;
        end else if (cmd_in.op == CH_RUN) begin
          pc_r <= 7'h00;
          direct_r <= 1'b0;
          loop_act_r <= 1'b0;
          until_on_r <= 1'b0;
          state_r <= ST_FETCH;
        end else if (cmd_in.op == CH_XCHG) begin
          copy_r <= 7'h00;
          state_r <= ST_LOAD;
        end else if (cmd_in.op == CH_INIT) begin
          if (cmd_in.arg == INIT_CLEAR) begin
            pos_r <= '0;
            ext_out_r <= 2'b00;
          end
        end else if (app_len > 3'd1 && arg_ok) begin
          cur_r <= cmd_in; // single command run at once
          direct_r <= 1'b1;
          state_r <= ST_EXEC;
        end else begin
          reply_r <= RP_ERR;
          reply_v_r <= 1'b1;
        end
      end
    end
  end

  // program ram and eeprom; no reset, eeprom contents are meant to persist
  always_ff @(posedge pclk) begin
    if (app_we) begin
      for (int k = 0; k < 4; k++) begin
        if (3'(k) < app_len) ram[wr_ptr_r + 7'(k)] <= app_bytes[31 - 8 * k -: 8];
      end
    end
    if (state_r == ST_LOAD) ram[copy_r] <= eeprom[copy_r];
    if (state_r == ST_SAVE) eeprom[copy_r] <= ram[copy_r];
  end

  // read data captured in the setup phase, so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        OFS_REPLY: prdata_r <= {23'h00_0000, reply_v_r, reply_r};
        OFS_STATUS: prdata_r <= {9'h000, pc_r, 5'h00, ext_out_r, in_vec, motion_r.dir,
          prog_err_r, prog_mode_r, motion_r.ramping, motion_r.moving, running};
        OFS_POS: prdata_r <= pos_r;
        default: prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !((paddr == OFS_CMD && pwrite)
    || ((paddr == OFS_REPLY || paddr == OFS_STATUS || paddr == OFS_POS) && !pwrite));
  assign ext_out_1 = ext_out_r[0];
  assign ext_out_2 = ext_out_r[1];
  assign motion = motion_r;

  // checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_cmd(logic [7:0] c);
    cmd_wr && cmd_in.op == c;
  endsequence

  chk_busy_reply: assert property ((running && cmd_wr && !allowed) |=>
    (reply_v_r && reply_r == RP_BUSY)) else $error("busy reply missing");
  chk_stop_halts: assert property (($fell(motion_r.moving) && $past(stop_req_r)) |->
    state_r == ST_IDLE) else $error("smooth stop did not halt");
  chk_idle_stop: assert property ((s_cmd(CH_ZERO) ##0 (running && !motion_r.moving)) |=>
    state_r == ST_IDLE) else $error("stop without motion not immediate");
  chk_pos_kept: assert property ((s_cmd(CH_ZERO) ##0 !motion_r.moving) |=>
    $stable(pos_r)) else $error("stop changed position");
  chk_step_count: assert property (motion_r.step |->
    pos_r == $past(pos_r) + (motion_r.dir ? -32'sd1 : 32'sd1)) else $error("step miscount");
  chk_move_len: assert property ((app_we && cmd_in.op == CH_PLUS) |=>
    wr_ptr_r == $past(wr_ptr_r) + 7'd4) else $error("relative move length wrong");
  chk_overflow_err: assert property ((cmd_wr && !running && prog_mode_r && app_len != 3'd0
    && !room) |=> (prog_err_r && reply_r == RP_ERR)) else $error("overflow not reported");
  chk_status_ready: assert property ((s_cmd(CH_STAT) ##0 !running) |=>
    (reply_v_r && reply_r == RP_READY)) else $error("ready not reported");
  chk_rate_scale: assert property ((state_r == ST_EXEC && cur_r.op == CH_SS) |=>
    ss_r == {cur_r.arg[16:0], 3'b000} + {cur_r.arg[18:0], 1'b0}) else $error("rate scale");
  chk_out_set: assert property ((state_r == ST_EXEC && cur_r.op == CH_SET
    && cur_r.arg == 20'h0_0001) |=> ext_out_1) else $error("output not set");
  chk_wait_hold: assert property ((state_r == ST_WAIT && !wait_bit && !cmd_wr) |=>
    state_r == ST_WAIT) else $error("wait released early");
  chk_run_ram: assert property ((s_cmd(CH_RUN) ##0 (!running && !prog_mode_r)) |=>
    (state_r == ST_FETCH && pc_r == 7'h00)) else $error("run did not start at zero");
endmodule

// ===== rtl/stpi_pkg.sv
package stpi_pkg;
  // register byte offsets
  localparam logic [11:0] OFS_CMD = 12'h000;
  localparam logic [11:0] OFS_REPLY = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_POS = 12'h00C;
  // program store
  localparam int PROG_DEPTH = 119;
  localparam logic [6:0] PROG_LAST = 7'h76;
  localparam logic [7:0] DEPTH_B = 8'h77;
  // timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int CLK_HZ = 1_000_000_000 / CLK_PERIOD_NS;
  localparam int DELAY_UNIT_NS = 100_000_000;
  localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [27:0] CLK_HZ_W = 28'(CLK_HZ);
  // argument limits and reset values
  localparam logic [19:0] MOVE_MAX = 20'hF_423F;
  localparam logic [19:0] INIT_CLEAR = 20'h0_0003;
  localparam logic [19:0] SS_RST = 20'h0_0064;
  localparam logic [19:0] SLEW_RST = 20'h0_03E8;
  localparam logic [15:0] RAMP_RST = 16'h0032;
  // command letters
  localparam logic [7:0] CH_ZERO = 8'h5A;
  localparam logic [7:0] CH_KILL = 8'h4B;
  localparam logic [7:0] CH_STAT = 8'h46;
  localparam logic [7:0] CH_PLUS = 8'h2B;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_GOTO = 8'h47;
  localparam logic [7:0] CH_SS = 8'h53;
  localparam logic [7:0] CH_SLEW = 8'h54;
  localparam logic [7:0] CH_RAMP = 8'h52;
  localparam logic [7:0] CH_SET = 8'h41;
  localparam logic [7:0] CH_CLR = 8'h43;
  localparam logic [7:0] CH_WAIT = 8'h57;
  localparam logic [7:0] CH_UNTIL = 8'h55;
  localparam logic [7:0] CH_LOOP = 8'h4C;
  localparam logic [7:0] CH_DELAY = 8'h44;
  localparam logic [7:0] CH_INIT = 8'h49;
  localparam logic [7:0] CH_PROG = 8'h50;
  localparam logic [7:0] CH_RUN = 8'h45;
  localparam logic [7:0] CH_SAVE = 8'h4D;
  localparam logic [7:0] CH_XCHG = 8'h58;
  // reply characters
  localparam logic [7:0] RP_BUSY = 8'h42;
  localparam logic [7:0] RP_READY = 8'h52;
  localparam logic [7:0] RP_RUN = 8'h4D;
  localparam logic [7:0] RP_ERR = 8'h3F;

  typedef struct packed {
    logic [19:0] arg;
    logic [7:0] op;
  } stpi_cmd_type;

  typedef struct packed {
    logic step;
    logic dir;
    logic moving;
    logic ramping;
  } stpi_motion_type;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_DIV, ST_MOVE, ST_WAIT, ST_DELAY, ST_SAVE, ST_LOAD
  } stpi_state_type;

  // stored length of a command in program locations, 0 when not storable
  function automatic logic [2:0] cmd_len(input logic [7:0] op);
    case (op)
      CH_PLUS, CH_MINUS, CH_GOTO: cmd_len = 3'd4;
      CH_SS, CH_SLEW, CH_RAMP: cmd_len = 3'd3;
      CH_SET, CH_CLR, CH_WAIT, CH_UNTIL, CH_LOOP, CH_DELAY: cmd_len = 3'd2;
      CH_RUN: cmd_len = 3'd1;
      default: cmd_len = 3'd0;
    endcase
  endfunction
endpackage

// ===== tb/stpi_host.sv
module stpi_host
  import stpi_pkg::*;
(
  input wire logic pclk,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic err_r;
  initial begin
    {paddr, psel, penable, pwrite, pwdata} = '0;
  end
  // one apb transfer; request held until pready is seen high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err_r = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// ===== tb/tb_stpi_interp.sv
module tb_stpi_interp;
  import stpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic ext_in_1 = 0, ext_in_2 = 0, ext_in_3 = 0, ext_out_1, ext_out_2;
  stpi_motion_type motion;
  int n_mismatch = 0, tests_run = 0, cyc = 0, n;
  stpi_interp #(.DELAY_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ext_in_1(ext_in_1), .ext_in_2(ext_in_2),
    .ext_in_3(ext_in_3), .ext_out_1(ext_out_1), .ext_out_2(ext_out_2), .motion(motion));
  stpi_host host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  always #4 pclk = ~pclk;
  // hang guard; the longest scenario is a few thousand cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // expected reply word: valid bit above the character
  function automatic logic [31:0] rp(input logic [7:0] c);
    return {23'h0, 1'b1, c};
  endfunction
  task automatic cmd(input logic [7:0] op, input logic [19:0] arg);
    host.xfer(1'b1, OFS_CMD, {4'h0, arg, op}, q);
  endtask
  task automatic rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, q);
  endtask
  // poll until not running; running out of polls counts as a mismatch
  task automatic wait_idle();
    for (int i = 0; i < 5000; i++) begin
      rd(OFS_STATUS);
      if (q[0] === 1'b0) return;
    end
    n_mismatch++;
    $display("Error at %0t: still running", $time);
  endtask
  initial begin
    void'($urandom(32'h0b8f));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_POS); check(q, 32'h0000_0000);
    // a write to a read-only register is refused with a bus error
    host.xfer(1'b1, OFS_STATUS, 32'h0000_0000, q); check(host.err_r, 1'b1);
    cmd(CH_STAT, 20'h0_0000); rd(OFS_REPLY); check(q, rp(RP_READY));
    cmd(CH_SET, 20'h0_0001); wait_idle(); check(ext_out_1, 1'b1);
    cmd(CH_SS, 20'h0_FFFF);
    cmd(CH_SLEW, 20'h0_FFFF);
    cmd(CH_RAMP, 20'h0_0001);
    n = $urandom_range(2, 8);
    ext_in_1 <= 1'($urandom);
    cmd(CH_PLUS, 20'(n));
    cmd(CH_CLR, 20'h0_0001); rd(OFS_REPLY); check(q, rp(RP_BUSY));
    check(ext_out_1, 1'b1);
    cmd(CH_STAT, 20'h0_0000); rd(OFS_REPLY); check(q, rp(RP_RUN));
    check(motion.moving, 1'b1);
    wait_idle();
    rd(OFS_POS); check(q, 32'(n));
    cmd(CH_MINUS, 20'(n + 1)); wait_idle();
    rd(OFS_POS); check(q, 32'hFFFF_FFFF);
    cmd(CH_INIT, INIT_CLEAR); rd(OFS_POS); check(q, 32'h0000_0000);
    check(ext_out_1, 1'b0);
    // smooth stop while the ramp divider runs: no ramp to walk, one last step
    cmd(CH_PLUS, 20'h0_0014); cmd(CH_ZERO, 20'h0_0000); wait_idle();
    rd(OFS_POS); check(q, 32'h0000_0001);
    // stored program: wait for input 3, then raise output 2
    cmd(CH_PROG, 20'h0_0000); cmd(CH_WAIT, 20'h0_0003); cmd(CH_SET, 20'h0_0002);
    cmd(CH_RUN, 20'h0_0000); rd(OFS_STATUS); check(q[0], 1'b1);
    check(ext_out_2, 1'b0);
    cmd(CH_ZERO, 20'h0_0000); rd(OFS_STATUS); check(q[0], 1'b0);
    cmd(CH_RUN, 20'h0_0000); rd(OFS_STATUS); check(q[0], 1'b1);
    ext_in_3 <= 1'b1;
    wait_idle(); check(ext_out_2, 1'b1);
    cmd(CH_PROG, 20'h0_0000); cmd(CH_SET, 20'h0_0005);
    rd(OFS_REPLY); check(q, rp(RP_ERR));
    cmd(CH_RUN, 20'h0_0000); rd(OFS_REPLY); check(q, rp(RP_ERR));
    // 29 four-location moves fill 116 locations, the 30th does not fit
    cmd(CH_PROG, 20'h0_0000);
    repeat (30) cmd(CH_PLUS, 20'h0_0001);
    rd(OFS_REPLY); check(q, rp(RP_ERR));
    cmd(CH_RUN, 20'h0_0000);
    stop_test();
  end
endmodule
